// >>> rtl/reset_entry_and_pin_states.sv
`timescale 1ns/10ps
// Summary of operation
// (RL1) The board must hold the reset pin low for at least 20 clocks.
// (RL2) After release with a stable clock, fetch starts at the reset vector.
// (RL3) A software reset gives the same state and startup as the pin reset.
// (RL4) In single-chip mode all ports float; ports 6 to 10 float always.
// (RL5) In bus mode port zero, hold and ready float, address is undefined.
// (RL6) Port one is data input on a 16-bit bus, plain input on 8-bit.
// (RL7) The first chip select is driven high in bus mode.
// (RL8) Write and read strobes are driven high in bus mode.
// (RL9) The address latch strobe is driven low in bus mode.
// (RL10) Bus release acknowledge follows the bus takeover request input.
// (RL11) Port four upper bits float with pull-ups on in bus mode.
// (RL12) The reset pin is synchronised and low samples are counted.
module reset_entry_and_pin_states (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Reset sources
   input wire logic i_reset_pin_n,
   input wire logic i_soft_reset,
   // Mode straps
   input wire logic i_processor_mode_pin,
   input wire logic i_bus_width_pin,
   // Main clock stable indication
   input wire logic i_main_clk_stable,
   // Bus takeover request pin
   input wire logic i_hold_req,
   // Core control
   output logic o_core_reset,
   output logic o_core_start,
   output logic [reset_seq_pkg::ADDR_PORT_BITS-1:0] o_start_addr,
   // Pin state overrides, output enables active low, pull-up enables active high
   output logic o_pin_override,
   output logic o_data_port_zero_oe_n,
   output logic o_data_port_one_oe_n,
   output logic o_data_port_one_is_data,
   output logic o_addr_oe_n,
   output logic o_first_chip_select_n,
   output logic o_first_chip_select_oe_n,
   output logic o_write_strobe_n,
   output logic o_read_strobe_n,
   output logic o_strobe_oe_n,
   output logic o_upper_byte_enable_oe_n,
   output logic o_bus_clk,
   output logic o_bus_clk_oe_n,
   output logic o_bus_release_ack,
   output logic o_bus_release_ack_oe_n,
   output logic o_addr_latch,
   output logic o_addr_latch_oe_n,
   output logic [2:0] o_port_four_upper_bits_pullup,
   output logic o_gen_ports_oe_n
);
   import reset_seq_pkg::*;

   logic hold_reset;
   logic mode_s1_q;
   logic mode_q;
   logic width_s1_q;
   logic width_q;
   logic stable_s1_q;
   logic stable_q;
   logic hold_s1_q;
   logic hold_q;
   logic soft_q;
   logic in_reset;
   logic bus_mode;
   logic [3:0] stable_cnt_q;
   seq_state_type state_q;

   // Qualified pin reset
   reset_filter u_filter (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_reset_pin_n(i_reset_pin_n),
      .o_hold_reset(hold_reset)
   );

   // Pins from outside pass two flops before use
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         mode_s1_q <= 1'h0;
         mode_q <= 1'h0;
         width_s1_q <= 1'h0;
         width_q <= 1'h0;
         stable_s1_q <= 1'h0;
         stable_q <= 1'h0;
         hold_s1_q <= 1'h1;
         hold_q <= 1'h1;
      end else begin
         mode_s1_q <= i_processor_mode_pin;
         mode_q <= mode_s1_q;
         width_s1_q <= i_bus_width_pin;
         width_q <= width_s1_q;
         stable_s1_q <= i_main_clk_stable;
         stable_q <= stable_s1_q;
         hold_s1_q <= i_hold_req;
         hold_q <= hold_s1_q;
      end
   end

   // Software reset is a one-cycle request from core logic
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         soft_q <= 1'h0;
      end else begin
         soft_q <= i_soft_reset;
      end
   end

   // Both sources enter the same state, so startup cannot differ
   assign in_reset = hold_reset || soft_q; // RL3
   assign bus_mode = mode_q;

   // Sequencer: reset, wait for clock stable, run
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         state_q <= ST_RESET;
      end else if (in_reset) begin
         state_q <= ST_RESET; // RL3
      end else begin
         case (state_q)
            ST_RESET: begin
               state_q <= ST_STABLE;
            end
            ST_STABLE: begin
               if (stable_q && stable_cnt_q == CLK_STABLE_CNT) begin
                  state_q <= ST_RUN; // RL2
               end
            end
            ST_RUN: begin
               state_q <= ST_RUN;
            end
            default: begin
               state_q <= ST_RESET;
            end
         endcase
      end
   end

   // Stable clock must persist for a while before release
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         stable_cnt_q <= 4'h0;
      end else if (state_q != ST_STABLE || !stable_q) begin
         stable_cnt_q <= 4'h0;
      end else if (stable_cnt_q != CLK_STABLE_CNT) begin
         stable_cnt_q <= stable_cnt_q + 4'h1;
      end
   end

   // Core reset and one-cycle start pulse with vector address
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_core_reset <= 1'h1;
         o_core_start <= 1'h0;
         o_start_addr <= RESET_VECTOR_ADDR;
      end else begin
         o_core_reset <= (state_q != ST_RUN) || in_reset;
         o_core_start <= (state_q == ST_STABLE) && !in_reset && stable_q
            && stable_cnt_q == CLK_STABLE_CNT; // RL2
         o_start_addr <= RESET_VECTOR_ADDR; // RL2
      end
   end

   // Bus clock keeps running during reset in bus mode
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_bus_clk <= BCLK_RESET_VAL;
      end else begin
         o_bus_clk <= !o_bus_clk; // RL5
      end
   end

   // Pin states while in reset; after release the ports own the pins
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_pin_override <= 1'h1;
         o_data_port_zero_oe_n <= 1'h1;
         o_data_port_one_oe_n <= 1'h1;
         o_data_port_one_is_data <= 1'h0;
         o_addr_oe_n <= 1'h1;
         o_first_chip_select_n <= 1'h1;
         o_first_chip_select_oe_n <= 1'h1;
         o_write_strobe_n <= 1'h1;
         o_read_strobe_n <= 1'h1;
         o_strobe_oe_n <= 1'h1;
         o_upper_byte_enable_oe_n <= 1'h1;
         o_bus_clk_oe_n <= 1'h1;
         o_bus_release_ack <= 1'h0;
         o_bus_release_ack_oe_n <= 1'h1;
         o_addr_latch <= 1'h0;
         o_addr_latch_oe_n <= 1'h1;
         o_port_four_upper_bits_pullup <= 3'h0;
         o_gen_ports_oe_n <= 1'h1;
      end else begin
         o_pin_override <= o_core_reset;
         // Data ports always float in reset
         o_data_port_zero_oe_n <= 1'h1; // RL4 RL5
         o_data_port_one_oe_n <= 1'h1; // RL6
         o_data_port_one_is_data <= bus_mode && !width_q; // RL6
         // Address and byte enable driven in bus mode, value undefined
         o_addr_oe_n <= !bus_mode; // RL4 RL5
         o_upper_byte_enable_oe_n <= !bus_mode; // RL5
         o_first_chip_select_n <= 1'h1; // RL7
         o_first_chip_select_oe_n <= !bus_mode; // RL7 RL4
         o_write_strobe_n <= 1'h1; // RL8
         o_read_strobe_n <= 1'h1; // RL8
         o_strobe_oe_n <= !bus_mode; // RL8 RL4
         o_bus_clk_oe_n <= !bus_mode; // RL5
         o_bus_release_ack <= !hold_q; // RL10
         o_bus_release_ack_oe_n <= !bus_mode; // RL10
         o_addr_latch <= 1'h0; // RL9
         o_addr_latch_oe_n <= !bus_mode; // RL9
         o_port_four_upper_bits_pullup <= {3{bus_mode}}; // RL11
         o_gen_ports_oe_n <= 1'h1; // RL4
      end
   end

   start_after_run_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_rstn)
      o_core_start |-> ##1 !o_core_reset [*2])
      else $error("core held in reset after start"); // RL2

   soft_same_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      soft_q |-> ##1 (state_q == ST_RESET) ##1 o_core_reset)
      else $error("software reset did not restart sequence"); // RL3

   single_float_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_rstn)
      !bus_mode ##1 1 |-> o_addr_oe_n && o_strobe_oe_n
      && o_first_chip_select_oe_n && o_addr_latch_oe_n)
      else $error("pin driven in single-chip mode"); // RL4

   gen_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_gen_ports_oe_n && o_data_port_zero_oe_n)
      else $error("general port driven in reset"); // RL4

   // Only attempts begun out of reset; the first one compares the first toggle against the reset value
   bus_clk_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_rstn ##1 1 |-> o_bus_clk != $past(o_bus_clk))
      else $error("bus clock stopped"); // RL5

   width_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      bus_mode && width_q ##1 bus_mode |-> !o_data_port_one_is_data)
      else $error("port one wrong for 8-bit bus"); // RL6

   select_high_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_rstn)
      bus_mode |=> o_first_chip_select_n && !o_first_chip_select_oe_n)
      else $error("chip select not driven high"); // RL7

   strobes_high_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_rstn)
      bus_mode |=> o_write_strobe_n && o_read_strobe_n && !o_strobe_oe_n)
      else $error("strobes not driven high"); // RL8

   latch_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      bus_mode |=> !o_addr_latch && !o_addr_latch_oe_n)
      else $error("address latch not driven low"); // RL9

   ack_follow_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_rstn)
      ##1 o_bus_release_ack == !$past(hold_q))
      else $error("release ack does not follow request"); // RL10

   pullup_on_a: assert property (@(posedge i_sys_clk)
      disable iff (!i_rstn)
      bus_mode |=> o_port_four_upper_bits_pullup == 3'h7)
      else $error("port four pull-ups off in bus mode"); // RL11
endmodule : reset_entry_and_pin_states

// >>> rtl/reset_filter.sv
`timescale 1ns/10ps
// Synchronises the reset pin and counts consecutive low samples
module reset_filter (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Reset pin from board
   input wire logic i_reset_pin_n,
   // Qualified reset request
   output logic o_hold_reset
);
   import reset_seq_pkg::*;

   logic sync1_q;
   logic sync2_q;
   logic [4:0] low_cnt_q;

   // Two-stage synchroniser; first stage read only by second
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         sync1_q <= 1'h1;
         sync2_q <= 1'h1;
      end else begin
         sync1_q <= i_reset_pin_n;
         sync2_q <= sync1_q;
      end
   end

   // Count consecutive low samples, saturating at the minimum
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         low_cnt_q <= 5'h00;
      end else if (sync2_q) begin
         low_cnt_q <= 5'h00; // RL12
      end else if (low_cnt_q != RESET_MIN_CNT) begin
         low_cnt_q <= low_cnt_q + 5'h01; // RL12
      end
   end

   // Glitches shorter than the minimum never reach the core
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_hold_reset <= 1'h0;
      end else if (sync2_q) begin
         o_hold_reset <= 1'h0;
      end else if (low_cnt_q == RESET_MIN_CNT - 5'h01) begin
         o_hold_reset <= 1'h1; // RL1 RL12
      end
   end

   short_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      $rose(o_hold_reset) |-> $past(low_cnt_q) == RESET_MIN_CNT - 5'h01)
      else $error("reset taken before minimum low time"); // RL12
endmodule : reset_filter

// >>> rtl/reset_seq_pkg.sv
package reset_seq_pkg;
   // Reset input must be low this many sampled cycles
   localparam int unsigned RESET_MIN_CYCLES = 20;
   localparam logic [4:0] RESET_MIN_CNT = 5'd20;
   // Clock rate
   localparam int unsigned CLK_PERIOD_NS = 40;
   // Cycles the main clock must run before release counts as stable
   localparam logic [3:0] CLK_STABLE_CNT = 4'd8;
   // Reset vector location (20-bit address space)
   localparam logic [19:0] RESET_VECTOR_ADDR = 20'hffffc;
   // Bus clock reset level; the clock toggles every cycle
   localparam logic [0:0] BCLK_RESET_VAL = 1'h0;
   // Port counts
   localparam int unsigned PORT_BITS = 8;
   localparam int unsigned ADDR_PORT_BITS = 20;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_RESET,
      ST_STABLE,
      ST_RUN
   } seq_state_type;
endpackage : reset_seq_pkg

// >>> test/board_reset_model.sv
`timescale 1ns/10ps
// Board reset circuit and bus master pins on the far side
module board_reset_model (
   // Clock
   input wire logic i_sys_clk,
   // Board pins
   output logic o_reset_pin_n,
   output logic o_hold_req
);
   // Pull-ups keep both pins high while nobody pulls them
   initial begin
      o_reset_pin_n = 1'h1;
      o_hold_req = 1'h1;
   end
   // Pin level changes land just after an edge
   task automatic pin_level(input logic v);
      @(posedge i_sys_clk);
      o_reset_pin_n <= v;
   endtask : pin_level
   task automatic hold_level(input logic v);
      @(posedge i_sys_clk);
      o_hold_req <= v;
   endtask : hold_level
endmodule : board_reset_model

// >>> test/reset_entry_and_pin_states_tb.sv
`timescale 1ns/10ps
module reset_entry_and_pin_states_tb;
   import reset_seq_pkg::*;
   logic i_sys_clk, i_rstn, i_soft_reset, i_processor_mode_pin;
   logic i_bus_width_pin, i_main_clk_stable, pin_n, hold_req;
   logic o_core_reset, o_core_start, o_pin_override, o_d0_oe_n, o_d1_oe_n;
   logic o_d1_is_data, o_addr_oe_n, o_cs_n, o_cs_oe_n, o_wr_n, o_rd_n;
   logic o_strobe_oe_n, o_ube_oe_n, o_bus_clk, o_bus_clk_oe_n, o_ack;
   logic o_ack_oe_n, o_ale, o_ale_oe_n, o_gen_oe_n;
   logic [2:0] o_pullup;
   logic [ADDR_PORT_BITS-1:0] o_start_addr;
   int failures = 0;
   int checked = 0;

   board_reset_model board_reset_model_inst (.i_sys_clk(i_sys_clk),
      .o_reset_pin_n(pin_n), .o_hold_req(hold_req));

   reset_entry_and_pin_states reset_entry_and_pin_states_inst (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reset_pin_n(pin_n),
      .i_soft_reset(i_soft_reset), .i_processor_mode_pin(i_processor_mode_pin),
      .i_bus_width_pin(i_bus_width_pin), .i_main_clk_stable(i_main_clk_stable),
      .i_hold_req(hold_req), .o_core_reset(o_core_reset),
      .o_core_start(o_core_start), .o_start_addr(o_start_addr),
      .o_pin_override(o_pin_override), .o_data_port_zero_oe_n(o_d0_oe_n),
      .o_data_port_one_oe_n(o_d1_oe_n), .o_data_port_one_is_data(o_d1_is_data),
      .o_addr_oe_n(o_addr_oe_n), .o_first_chip_select_n(o_cs_n),
      .o_first_chip_select_oe_n(o_cs_oe_n), .o_write_strobe_n(o_wr_n),
      .o_read_strobe_n(o_rd_n), .o_strobe_oe_n(o_strobe_oe_n),
      .o_upper_byte_enable_oe_n(o_ube_oe_n), .o_bus_clk(o_bus_clk),
      .o_bus_clk_oe_n(o_bus_clk_oe_n), .o_bus_release_ack(o_ack),
      .o_bus_release_ack_oe_n(o_ack_oe_n), .o_addr_latch(o_ale),
      .o_addr_latch_oe_n(o_ale_oe_n),
      .o_port_four_upper_bits_pullup(o_pullup), .o_gen_ports_oe_n(o_gen_oe_n));

   // 25 MHz clock
   initial begin
      i_sys_clk = 1'h0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string name, input logic [19:0] exp,
         input logic [19:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : cyc

   // Strap and clock-stable levels change at a rising edge
   task automatic drive_straps(input logic m, input logic w, input logic s);
      @(posedge i_sys_clk);
      i_processor_mode_pin <= m;
      i_bus_width_pin <= w;
      i_main_clk_stable <= s;
   endtask : drive_straps

   // Bounded wait for the start pulse, then vector and pulse width
   task automatic wait_start(input int limit);
      logic seen;
      seen = 1'h0;
      for (int i = 0; i < limit && !seen; i++) begin
         cyc(1);
         seen = o_core_start;
      end
      chk("core_start", 20'h1, seen);
      chk("start_addr", RESET_VECTOR_ADDR, o_start_addr);
      cyc(1);
      chk("start_pulse", 20'h0, o_core_start);
      chk("core_reset_off", 20'h0, o_core_reset);
   endtask : wait_start

   // Short glitch must leave the core running
   task automatic t_glitch();
      logic any;
      any = 1'h0;
      board_reset_model_inst.pin_level(1'h0);
      cyc(10);
      board_reset_model_inst.pin_level(1'h1);
      for (int i = 0; i < 40; i++) begin
         cyc(1);
         any = any | o_core_reset | o_pin_override;
      end
      chk("glitch_reset", 20'h0, any);
   endtask : t_glitch

   // Bus mode pin states, then release waiting on clock stable
   task automatic t_bus(input logic w);
      logic b;
      drive_straps(1'h1, w, 1'h0);
      board_reset_model_inst.pin_level(1'h0);
      cyc(35);
      chk("core_reset", 20'h1, o_core_reset);
      chk("override", 20'h1, o_pin_override);
      chk("port_oe", 20'h7, {o_d0_oe_n, o_d1_oe_n, o_gen_oe_n});
      chk("p1_is_data", {19'h0, ~w}, o_d1_is_data);
      chk("addr_ube_oe", 20'h0, {o_addr_oe_n, o_ube_oe_n});
      chk("cs", 20'h2, {o_cs_n, o_cs_oe_n});
      chk("strobes", 20'h6, {o_wr_n, o_rd_n, o_strobe_oe_n});
      chk("ale", 20'h0, {o_ale, o_ale_oe_n});
      chk("pullup", 20'h7, o_pullup);
      b = o_bus_clk;
      cyc(1);
      chk("bus_clk", {19'h0, ~b}, o_bus_clk);
      chk("bus_clk_oe", 20'h0, o_bus_clk_oe_n);
      board_reset_model_inst.hold_level(1'h0);
      cyc(6);
      chk("ack_low_hold", 20'h1, o_ack);
      chk("ack_oe", 20'h0, o_ack_oe_n);
      board_reset_model_inst.hold_level(1'h1);
      cyc(6);
      chk("ack_high_hold", 20'h0, o_ack);
      board_reset_model_inst.pin_level(1'h1);
      cyc(20);
      chk("unstable_hold", 20'h1, o_core_reset);
      drive_straps(1'h1, w, 1'h1);
      wait_start(30);
   endtask : t_bus

   // System reset in mid-run, in bus mode, floats the bus pins again
   task automatic t_sys_reset();
      @(posedge i_sys_clk);
      i_rstn <= 1'h0;
      cyc(2);
      chk("rst_core_reset", 20'h1, o_core_reset);
      chk("rst_oe", 20'h1f, {o_addr_oe_n, o_cs_oe_n, o_strobe_oe_n,
         o_bus_clk_oe_n, o_ale_oe_n});
      @(posedge i_sys_clk);
      i_rstn <= 1'h1;
      wait_start(40);
   endtask : t_sys_reset

   // Single chip mode floats every pin
   task automatic t_single();
      drive_straps(1'h0, 1'h0, 1'h1);
      board_reset_model_inst.pin_level(1'h0);
      cyc(35);
      chk("p1_plain", 20'h0, o_d1_is_data);
      chk("all_oe", 20'h3ff, {o_d0_oe_n, o_d1_oe_n, o_gen_oe_n, o_addr_oe_n,
         o_cs_oe_n, o_strobe_oe_n, o_ube_oe_n, o_bus_clk_oe_n, o_ack_oe_n,
         o_ale_oe_n});
      chk("no_pullup", 20'h0, o_pullup);
      board_reset_model_inst.pin_level(1'h1);
      wait_start(40);
   endtask : t_single

   // Soft reset restarts like the pin
   task automatic t_soft();
      @(posedge i_sys_clk);
      i_soft_reset <= 1'h1;
      @(posedge i_sys_clk);
      i_soft_reset <= 1'h0;
      cyc(1);
      chk("soft_reset", 20'h1, o_core_reset);
      wait_start(30);
   endtask : t_soft

   task automatic report_and_stop();
      if (failures == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      i_rstn = 1'h0;
      i_soft_reset = 1'h0;
      i_processor_mode_pin = 1'h0;
      i_bus_width_pin = 1'h0;
      i_main_clk_stable = 1'h1;
      repeat (6) @(posedge i_sys_clk);
      i_rstn <= 1'h1;
      wait_start(40);
      t_glitch();
      t_bus(1'h0);
      t_bus(1'h1);
      t_sys_reset();
      t_single();
      t_soft();
      report_and_stop();
   end

   // Watchdog, well past the few hundred cycles needed
   initial begin
      repeat (3000) @(posedge i_sys_clk);
      failures++;
      report_and_stop();
   end
endmodule : reset_entry_and_pin_states_tb
